//--- ccr_top.v
/*
  Charger configuration register bank with its write-word serial slave,
  the charge watchdog and the decoded configuration outputs.
  Assumes open-drain serial pins resolved outside and asynchronous
  comparator levels from the analog side.
*/
`timescale 1ns/1ns
`include "ccr_regs.vh"

module ccr_top #(
  parameter [27:0] WDT_TICKS = `CCR_WDT_TICKS
) (
  // Clock and reset
  input  wire        REF_CLK,
  input  wire        SRST,
  // Serial bus pins
  input  wire        SCL_I,
  input  wire        SDA_I,
  output wire        SDA_O,
  output wire        SDA_OE,
  // Analog conditions
  input  wire        ADAPTER_PRESENT,
  input  wire        BATT_LOW_POWER,
  input  wire        AC_OC_CMP,
  input  wire        DC_OC_CMP,
  input  wire        LOW_RAIL_CMP,
  // Throttle alert open-drain pin, active low
  input  wire        ALERT_N_I,
  output wire        ALERT_N_O,
  output wire        ALERT_N_OE,
  // Decoded configuration
  output reg         CHARGE_EN,
  output reg         VIN_LOOP_EN,
  output reg         DCHG_THR_FROM_CFG,
  output reg  [4:0]  DCHG_THR_AMPS,
  output reg         DC_DETECT_EN,
  output reg  [9:0]  HS_SHORT_MV,
  output reg  [3:0]  BOOST_OFS_HALF_MV,
  output reg         CEIL_WR
);

  localparam [6:0] TICK_LAST = `CCR_TICK_LAST;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_CMD  = 3'h2;
  localparam [2:0] S_WLO  = 3'h3;
  localparam [2:0] S_WHI  = 3'h4;
  localparam [2:0] S_RLO  = 3'h5;
  localparam [2:0] S_RHI  = 3'h6;
  localparam [2:0] S_IGN  = 3'h7;

  reg  [7:0]  meta_reg;
  reg  [7:0]  sync_reg;
  reg         scl_d_reg;
  reg         sda_d_reg;
  reg  [6:0]  div_reg;
  reg  [2:0]  st_reg;
  reg  [3:0]  bit_reg;
  reg  [7:0]  sh_reg;
  reg  [7:0]  tx_reg;
  reg  [7:0]  cmd_reg;
  reg  [7:0]  lo_reg;
  reg         rd_ack_reg;
  reg         sda_oe_reg;
  reg  [15:0] cfg0_reg;
  reg  [15:0] cfg1_reg;
  reg  [15:0] cfg2_reg;
  reg  [15:0] cfg3_reg;
  reg  [15:0] cfg4_reg;
  reg  [27:0] wdt_reg;
  reg         wdt_exp_reg;
  reg  [15:0] rd_word;
  wire        scl_s;
  wire        sda_s;
  wire        adp_s;
  wire        blp_s;
  wire        tick;
  wire        start_ev;
  wire        stop_ev;
  wire        scl_rise;
  wire        scl_fall;
  wire        wdt_on;
  wire        dc_en;
  wire        alert_act;

  // ****************************************************************
  // Input synchronisers and edge detection
  // ****************************************************************
  always @(posedge REF_CLK) begin
    if (SRST) begin
      meta_reg  <= 8'hC0;
      sync_reg  <= 8'hC0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      meta_reg  <= {SCL_I, SDA_I, ADAPTER_PRESENT, BATT_LOW_POWER,
                    AC_OC_CMP, DC_OC_CMP, LOW_RAIL_CMP, ALERT_N_I};
      sync_reg  <= meta_reg;
      scl_d_reg <= sync_reg[7];
      sda_d_reg <= sync_reg[6];
    end
  end

  // Named views of the synchronised levels
  assign scl_s    = sync_reg[7];
  assign sda_s    = sync_reg[6];
  assign adp_s    = sync_reg[5];
  assign blp_s    = sync_reg[4];
  assign start_ev = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_ev  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign SDA_O    = 1'b0;
  assign SDA_OE   = sda_oe_reg;

  // ****************************************************************
  // 1 us tick divider
  // ****************************************************************
  always @(posedge REF_CLK) begin
    if (SRST || div_reg == TICK_LAST)
      div_reg <= 7'h00;
    else
      div_reg <= div_reg + 7'h01;
  end
  assign tick = (div_reg == TICK_LAST);

  // Read data selection
  always @* begin
    case (cmd_reg)
      `CCR_CMD_CFG0:   rd_word = cfg0_reg;
      `CCR_CMD_CFG1:   rd_word = cfg1_reg;
      `CCR_CMD_CFG2:   rd_word = cfg2_reg;
      `CCR_CMD_CFG3:   rd_word = cfg3_reg;
      `CCR_CMD_CFG4:   rd_word = cfg4_reg;
      `CCR_CMD_STATUS: rd_word = {12'h000, !sync_reg[0], CHARGE_EN, alert_act, wdt_exp_reg};
      default:         rd_word = 16'h0000;
    endcase
  end

  // ****************************************************************
  // Write-word and read-word serial slave with register file
  // ****************************************************************
  always @(posedge REF_CLK) begin
    if (SRST) begin
      st_reg     <= S_IDLE;
      bit_reg    <= 4'h0;
      sh_reg     <= 8'h00;
      tx_reg     <= 8'h00;
      cmd_reg    <= 8'h00;
      lo_reg     <= 8'h00;
      rd_ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      CEIL_WR    <= 1'b0;
      cfg0_reg   <= `CCR_CFG_RST;
      cfg1_reg   <= `CCR_CFG_RST;
      cfg2_reg   <= `CCR_CFG_RST;
      cfg3_reg   <= `CCR_CFG_RST;
      cfg4_reg   <= `CCR_CFG_RST;
    end else begin
      CEIL_WR <= 1'b0;
      if (start_ev) begin
        st_reg     <= S_ADDR;
        bit_reg    <= 4'hF; // Skip the clock fall that closes the start
        sda_oe_reg <= 1'b0;
      end else if (stop_ev) begin
        st_reg     <= S_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (st_reg != S_IDLE && st_reg != S_IGN) begin
        // Sample data bits and the master acknowledge
        if (scl_rise) begin
          if (bit_reg != 4'h8)
            sh_reg <= {sh_reg[6:0], sda_s};
          else
            rd_ack_reg <= !sda_s;
        end
        if (scl_fall) begin
          if (bit_reg == 4'hF) begin
            // Fall that closes a start: the first data bit follows
            bit_reg <= 4'h0;
          end else if (bit_reg < 4'h7) begin
            bit_reg <= bit_reg + 4'h1;
            if (st_reg == S_RLO || st_reg == S_RHI) begin
              sda_oe_reg <= !tx_reg[6];
              tx_reg     <= {tx_reg[6:0], 1'b0};
            end
          end else if (bit_reg == 4'h7) begin
            // Ninth clock: acknowledge our writes, release for reads
            bit_reg <= 4'h8;
            case (st_reg)
              S_ADDR: begin
                if (sh_reg[7:1] == `CCR_SLAVE_ADDR)
                  sda_oe_reg <= 1'b1;
                else
                  st_reg <= S_IGN;
              end
              S_CMD, S_WLO, S_WHI: sda_oe_reg <= 1'b1;
              default: sda_oe_reg <= 1'b0;
            endcase
          end else begin
            bit_reg    <= 4'h0;
            sda_oe_reg <= 1'b0;
            case (st_reg)
              S_ADDR: begin
                if (sh_reg[0]) begin
                  st_reg     <= S_RLO;
                  tx_reg     <= rd_word[7:0];
                  sda_oe_reg <= !rd_word[7];
                end else begin
                  st_reg <= S_CMD;
                end
              end
              S_CMD: begin
                cmd_reg <= sh_reg;
                st_reg  <= S_WLO;
              end
              S_WLO: begin
                lo_reg <= sh_reg;
                st_reg <= S_WHI;
              end
              S_WHI: begin
                // Commit the word; later bytes of the frame are ignored
                st_reg <= S_IGN;
                case (cmd_reg)
                  `CCR_CMD_CFG0: cfg0_reg <= {sh_reg, lo_reg};
                  `CCR_CMD_CFG1: cfg1_reg <= {sh_reg, lo_reg};
                  `CCR_CMD_CFG2: cfg2_reg <= {sh_reg, lo_reg};
                  `CCR_CMD_CFG3: cfg3_reg <= {sh_reg, lo_reg};
                  `CCR_CMD_CFG4: cfg4_reg <= {sh_reg, lo_reg};
                  `CCR_CMD_CHG_CUR, `CCR_CMD_CHG_VOLT: CEIL_WR <= 1'b1;
                  default: CEIL_WR <= 1'b0;
                endcase
              end
              S_RLO: begin
                if (rd_ack_reg) begin
                  st_reg     <= S_RHI;
                  tx_reg     <= rd_word[15:8];
                  sda_oe_reg <= !rd_word[15];
                end else begin
                  st_reg <= S_IGN;
                end
              end
              default: st_reg <= S_IGN;
            endcase
          end
        end
      end
    end
  end

  // ****************************************************************
  // Charge watchdog
  // ****************************************************************
  assign wdt_on = !cfg0_reg[`CCR_CFG0_WDT_DIS] && adp_s;

  // Timeout set wins over a ceiling write in the same cycle
  always @(posedge REF_CLK) begin
    if (SRST) begin
      wdt_reg     <= 28'h0000000;
      wdt_exp_reg <= 1'b0;
    end else begin
      if (CEIL_WR || !wdt_on)
        wdt_reg <= 28'h0000000;
      else if (tick && !wdt_exp_reg)
        wdt_reg <= wdt_reg + 28'h0000001;
      if (wdt_on && tick && !wdt_exp_reg && wdt_reg == WDT_TICKS - 28'h0000001)
        wdt_exp_reg <= 1'b1;
      else if (CEIL_WR)
        wdt_exp_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Throttle alert
  // ****************************************************************
  assign dc_en = adp_s || cfg1_reg[`CCR_CFG1_PMON_EN];

  ccr_alert u_alert (
    .clk       (REF_CLK),
    .srst      (SRST),
    .tick      (tick),
    .deb_code  (cfg2_reg[`CCR_CFG2_DEB_HI:`CCR_CFG2_DEB_LO]),
    .hold_code (cfg2_reg[`CCR_CFG2_HOLD_HI:`CCR_CFG2_HOLD_LO]),
    .cur_trip  (sync_reg[3] || (sync_reg[2] && dc_en)),
    .rail_trip (sync_reg[1]),
    .alert_reg (alert_act)
  );
  assign ALERT_N_O  = 1'b0;
  assign ALERT_N_OE = alert_act;

  // ****************************************************************
  // Registered configuration decode
  // ****************************************************************
  always @(posedge REF_CLK) begin
    if (SRST) begin
      CHARGE_EN         <= 1'b0;
      VIN_LOOP_EN       <= 1'b0;
      DCHG_THR_FROM_CFG <= 1'b0;
      DCHG_THR_AMPS     <= 5'h0C;
      DC_DETECT_EN      <= 1'b0;
      HS_SHORT_MV       <= 10'h190;
      BOOST_OFS_HALF_MV <= 4'h0;
    end else begin
      CHARGE_EN         <= !wdt_exp_reg;
      VIN_LOOP_EN       <= !cfg0_reg[`CCR_CFG0_VIN_DIS];
      DCHG_THR_FROM_CFG <= !adp_s && blp_s;
      DC_DETECT_EN      <= dc_en;
      case (cfg0_reg[`CCR_CFG0_DCT_HI:`CCR_CFG0_DCT_LO])
        2'h0: DCHG_THR_AMPS <= 5'h0C;
        2'h1: DCHG_THR_AMPS <= 5'h0A;
        2'h2: DCHG_THR_AMPS <= 5'h08;
        default: DCHG_THR_AMPS <= 5'h06;
      endcase
      case (cfg0_reg[`CCR_CFG0_HSS_HI:`CCR_CFG0_HSS_LO])
        2'h0: HS_SHORT_MV <= 10'h190;
        2'h1: HS_SHORT_MV <= 10'h1F4;
        2'h2: HS_SHORT_MV <= 10'h258;
        default: HS_SHORT_MV <= 10'h320;
      endcase
      // Sign extension turns codes 4..7 into -4..-1 half millivolts
      BOOST_OFS_HALF_MV <= {cfg0_reg[`CCR_CFG0_OFS_HI],
                            cfg0_reg[`CCR_CFG0_OFS_HI:`CCR_CFG0_OFS_LO]};
    end
  end

endmodule

//--- ccr_regs.vh
/*
  Constants of the charger configuration register bank: command codes,
  field positions, reset values and timing counts.
  Assumes a 100 MHz reference clock and a 1 us timing tick.
*/
`ifndef CCR_REGS_VH
`define CCR_REGS_VH

// ****************************************************************
// Bus addressing
// ****************************************************************
`define CCR_SLAVE_ADDR    7'h09
`define CCR_CMD_CFG0      8'h39
`define CCR_CMD_CFG1      8'h3C
`define CCR_CMD_CFG2      8'h3D
`define CCR_CMD_CFG3      8'h4C
`define CCR_CMD_CFG4      8'h4E
`define CCR_CMD_STATUS    8'h50
`define CCR_CMD_CHG_CUR   8'h14
`define CCR_CMD_CHG_VOLT  8'h15

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define CCR_CFG_RST       16'h0000
`define CCR_CFG0_OFS_HI   12
`define CCR_CFG0_OFS_LO   10
`define CCR_CFG0_WDT_DIS  7
`define CCR_CFG0_HSS_HI   6
`define CCR_CFG0_HSS_LO   5
`define CCR_CFG0_DCT_HI   4
`define CCR_CFG0_DCT_LO   3
`define CCR_CFG0_VIN_DIS  2
`define CCR_CFG1_PMON_EN  3
`define CCR_CFG2_DEB_HI   10
`define CCR_CFG2_DEB_LO   9
`define CCR_CFG2_HOLD_HI  8
`define CCR_CFG2_HOLD_LO  6
`define CCR_ST_WDT_EXP    0
`define CCR_ST_ALERT      1
`define CCR_ST_CHARGE     2
`define CCR_ST_PIN_LOW    3

// ****************************************************************
// Timing
// ****************************************************************
`define CCR_CLK_NS        10
`define CCR_TICK_NS       1000
`define CCR_TICK_DIV      (`CCR_TICK_NS / `CCR_CLK_NS)
`define CCR_TICK_LAST     7'h63       // Last divider count, 100 clocks a tick
`define CCR_WDT_S         175
`define CCR_WDT_TICKS     28'hA6E49C0 // 175 s counted in 1 us ticks
`define CCR_LOWRAIL_US    20'h0000A
`define CCR_DEB_US0       20'd10
`define CCR_DEB_US1       20'd100
`define CCR_DEB_US2       20'd500
`define CCR_DEB_US3       20'd1000
`define CCR_HOLD_US0      20'd10
`define CCR_HOLD_US1      20'd100
`define CCR_HOLD_US2      20'd500
`define CCR_HOLD_US3      20'd1000
`define CCR_HOLD_US4      20'd5000
`define CCR_HOLD_US5      20'd10000
`define CCR_HOLD_US6      20'd50000
`define CCR_HOLD_US7      20'd100000

`endif

//--- ccr_alert.v
/*
  Throttle alert timing: debounce of current and low-rail alerts and the
  minimum hold of the asserted alert.
  Assumes synchronised comparator levels and a one-cycle 1 us tick.
*/
`timescale 1ns/1ns
`include "ccr_regs.vh"

module ccr_alert (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  input  wire        tick,
  // Configuration
  input  wire [1:0]  deb_code,
  input  wire [2:0]  hold_code,
  // Conditions
  input  wire        cur_trip,
  input  wire        rail_trip,
  // Result
  output reg         alert_reg
);

  reg [19:0] deb_reg;
  reg [19:0] rail_reg;
  reg [19:0] hold_reg;
  wire [19:0] deb_lim;
  wire [19:0] rail_lim;
  wire        fire;

  // ****************************************************************
  // Code decoders
  // ****************************************************************
  function [19:0] deb_us;
    input [1:0] c;
    begin
      case (c)
        2'h0: deb_us = `CCR_DEB_US0;
        2'h1: deb_us = `CCR_DEB_US1;
        2'h2: deb_us = `CCR_DEB_US2;
        default: deb_us = `CCR_DEB_US3;
      endcase
    end
  endfunction

  function [19:0] hold_us;
    input [2:0] c;
    begin
      case (c)
        3'h0: hold_us = `CCR_HOLD_US0;
        3'h1: hold_us = `CCR_HOLD_US1;
        3'h2: hold_us = `CCR_HOLD_US2;
        3'h3: hold_us = `CCR_HOLD_US3;
        3'h4: hold_us = `CCR_HOLD_US4;
        3'h5: hold_us = `CCR_HOLD_US5;
        3'h6: hold_us = `CCR_HOLD_US6;
        default: hold_us = `CCR_HOLD_US7;
      endcase
    end
  endfunction

  // Limits and trip decision
  assign deb_lim  = deb_us(deb_code);
  assign rail_lim = `CCR_LOWRAIL_US;
  assign fire     = (cur_trip && deb_reg >= deb_lim) || (rail_trip && rail_reg >= rail_lim);

  // ****************************************************************
  // Debounce counters, hold counter and alert latch
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      deb_reg   <= 20'h00000;
      rail_reg  <= 20'h00000;
      hold_reg  <= 20'h00000;
      alert_reg <= 1'b0;
    end else begin
      // Counters restart whenever the condition drops
      if (!cur_trip)
        deb_reg <= 20'h00000;
      else if (tick && deb_reg < deb_lim)
        deb_reg <= deb_reg + 20'h00001;
      if (!rail_trip)
        rail_reg <= 20'h00000;
      else if (tick && rail_reg < rail_lim)
        rail_reg <= rail_reg + 20'h00001;
      // Assert on fire, release only after the hold time and with no debounced trip
      if (fire && !alert_reg) begin
        alert_reg <= 1'b1;
        hold_reg  <= hold_us(hold_code);
      end else if (alert_reg) begin
        if (tick && hold_reg != 20'h00000)
          hold_reg <= hold_reg - 20'h00001;
        if (hold_reg == 20'h00000 && !fire)
          alert_reg <= 1'b0;
      end
    end
  end

endmodule

//--- ccr_host.sv
/*
  Bus master model: write-word and read-word frames on SCL and SDA.
  Assumes the testbench resolves SDA as a pulled-up open-drain wire.
*/
`timescale 1ns/1ns
module ccr_host #(
  parameter int HALF = 15
) (
  // Clock and bus
  input  wire  clk,
  input  wire  sda,
  output logic scl,
  output logic sda_low
);
  // ****************************************
  // Bit level
  // ****************************************
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data set in the low phase, sampled at the end of the high phase
  task automatic xbit(input logic b, output logic r);
    wt(4);
    sda_low = !b;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    r = sda;
    scl = 1'b0;
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start();
    wt(4);
    sda_low = 1'b0;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask
  // Stop: data rises while clock high, bus left released
  task automatic stop();
    wt(4);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge clock
  task automatic xbyte(input logic [7:0] d, input logic ak, output logic [7:0] r,
                       output logic a);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r[i]);
    end
    xbit(ak, a);
  endtask
  // ****************************************
  // Frames
  // ****************************************
  // Write-word; acks bits are 0 where the byte was taken
  task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd,
                            input logic [15:0] d, output logic [3:0] acks);
    logic [7:0] r;
    start();
    xbyte({adr, 1'b0}, 1'b1, r, acks[3]);
    xbyte(cmd, 1'b1, r, acks[2]);
    xbyte(d[7:0], 1'b1, r, acks[1]);
    xbyte(d[15:8], 1'b1, r, acks[0]);
    stop();
  endtask
  // Read-word: low byte acked, high byte not acked
  task automatic read_word(input logic [6:0] adr, input logic [7:0] cmd,
                           output logic [15:0] d);
    logic a;
    start();
    xbyte({adr, 1'b0}, 1'b1, d[7:0], a);
    xbyte(cmd, 1'b1, d[7:0], a);
    start();
    xbyte({adr, 1'b1}, 1'b1, d[7:0], a);
    xbyte(8'hFF, 1'b0, d[7:0], a);
    xbyte(8'hFF, 1'b1, d[15:8], a);
    stop();
  endtask
endmodule

//--- ccr_assertions.sv
/*
  Checker of the register bank top: release decode, watchdog,
  throttle alert timing and threshold source selection.
  Assumes one clock REF_CLK and synchronous reset SRST.
*/
`timescale 1ns/1ns
module ccr_checker (
  // Clock and reset
  input logic       REF_CLK,
  input logic       SRST,
  // Conditions
  input logic       ADAPTER_PRESENT,
  input logic       BATT_LOW_POWER,
  input logic       AC_OC_CMP,
  input logic       DC_OC_CMP,
  input logic       LOW_RAIL_CMP,
  // Outputs watched
  input logic       ALERT_N_OE,
  input logic       CHARGE_EN,
  input logic       VIN_LOOP_EN,
  input logic       DCHG_THR_FROM_CFG,
  input logic       DC_DETECT_EN,
  input logic [9:0] HS_SHORT_MV,
  input logic       CEIL_WR
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  logic [16:0] hold_cnt;
  logic [16:0] trip_cnt;
  logic [16:0] rail_cnt;
  // ****************************************
  // Run lengths of the alert and its causes
  // ****************************************
  // Saturating counts of consecutive high cycles
  always @(posedge REF_CLK) begin
    if (SRST) begin
      hold_cnt <= 17'h00000;
      trip_cnt <= 17'h00000;
      rail_cnt <= 17'h00000;
    end else begin
      hold_cnt <= !ALERT_N_OE ? 17'h00000 : hold_cnt + {16'h0000, hold_cnt != 17'h1FFFF};
      trip_cnt <= !(AC_OC_CMP | DC_OC_CMP | LOW_RAIL_CMP) ? 17'h00000 :
                  trip_cnt + {16'h0000, trip_cnt != 17'h1FFFF};
      rail_cnt <= !LOW_RAIL_CMP ? 17'h00000 : rail_cnt + {16'h0000, rail_cnt != 17'h1FFFF};
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  a_release_decode: assert property ($fell(SRST) |-> !CHARGE_EN ##1 CHARGE_EN && VIN_LOOP_EN
    && HS_SHORT_MV == 10'h190) else $error("decode after reset wrong");
  a_ceil_pulse: assert property (CEIL_WR |=> !CEIL_WR)
    else $error("ceiling write pulse too long");
  a_ceil_resume: assert property (CEIL_WR |-> ##[1:3] CHARGE_EN)
    else $error("charging not resumed by ceiling write");
  a_wdt_adapter: assert property ($fell(CHARGE_EN) |-> $past(ADAPTER_PRESENT, 5))
    else $error("charging stopped without adapter");
  a_detect_adapter: assert property (ADAPTER_PRESENT [*6] |-> DC_DETECT_EN
    && !DCHG_THR_FROM_CFG) else $error("adapter present decode wrong");
  a_batt_thr_src: assert property ((!ADAPTER_PRESENT && BATT_LOW_POWER) [*6]
    |-> DCHG_THR_FROM_CFG) else $error("battery only threshold source wrong");
  a_alert_debounce: assert property ($rose(ALERT_N_OE) |-> trip_cnt >= 17'h00352)
    else $error("alert asserted before debounce");
  a_alert_hold: assert property ($fell(ALERT_N_OE) |-> hold_cnt >= 17'h00384)
    else $error("alert released before minimum hold");
  // Rail trip seen up to the edge before the rise: fixed debounce, not late
  a_rail_bound: assert property ($rose(ALERT_N_OE) && $past(LOW_RAIL_CMP) |->
    rail_cnt <= 17'h003F2) else $error("low rail alert late");
  // Main scenarios reached
  cover property (CEIL_WR);
  cover property ($rose(ALERT_N_OE));
  cover property ($fell(CHARGE_EN));
endmodule
bind ccr_top ccr_checker i_chk (.REF_CLK, .SRST, .ADAPTER_PRESENT, .BATT_LOW_POWER,
  .AC_OC_CMP, .DC_OC_CMP, .LOW_RAIL_CMP, .ALERT_N_OE, .CHARGE_EN, .VIN_LOOP_EN,
  .DCHG_THR_FROM_CFG, .DC_DETECT_EN, .HS_SHORT_MV, .CEIL_WR);

//--- tb_top.sv
/*
  Testbench of the register bank: word access, word zero decode,
  watchdog and throttle alert timing.
  Assumes ccr_host as bus master and pulled-up SDA and alert wires.
*/
`timescale 1ns/1ns
`include "ccr_regs.vh"
module tb_top;
  logic        ref_clk;
  logic        srst;
  logic        adapter;
  logic        batt_lp;
  logic [2:0]  trip;
  wire         scl;
  wire         sda_low;
  wire         sda_oe;
  wire         alert_oe;
  wire         charge_en;
  wire         vin_en;
  wire         thr_cfg;
  wire   [4:0] amps;
  wire   [9:0] hs_mv;
  wire   [3:0] ofs;
  wire         sda = !(sda_low | sda_oe);
  int          errors;
  int          check_count;
  int          n;
  logic [15:0] rd;
  logic [3:0]  acks;
  logic [7:0]  cmds [5] = '{8'h39, 8'h3C, 8'h3D, 8'h4C, 8'h4E};
  logic [15:0] vals [5] = '{16'h1C3B, 16'hA5F7, 16'h5A3C, 16'hFFFF, 16'h8001};
  logic [9:0]  hs_tab [4] = '{10'h190, 10'h1F4, 10'h258, 10'h320};
  // ****************************************
  // Instances
  // ****************************************
  ccr_host #(.HALF(15)) i_host (.clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ccr_top #(.WDT_TICKS(28'h0000014)) i_dut (.REF_CLK(ref_clk), .SRST(srst), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .ADAPTER_PRESENT(adapter),
    .BATT_LOW_POWER(batt_lp), .AC_OC_CMP(trip[0]), .DC_OC_CMP(trip[1]),
    .LOW_RAIL_CMP(trip[2]), .ALERT_N_I(!alert_oe), .ALERT_N_O(), .ALERT_N_OE(alert_oe),
    .CHARGE_EN(charge_en), .VIN_LOOP_EN(vin_en), .DCHG_THR_FROM_CFG(thr_cfg),
    .DCHG_THR_AMPS(amps), .DC_DETECT_EN(), .HS_SHORT_MV(hs_mv),
    .BOOST_OFS_HALF_MV(ofs), .CEIL_WR());
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    i_host.write_word(`CCR_SLAVE_ADDR, cmd, d, acks);
    chk("write acks", 16'h0000, {12'h000, acks});
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
    i_host.read_word(`CCR_SLAVE_ADDR, cmd, rd);
    chk("read word", exp, rd);
  endtask
  // Bounded wait for alert (sel 0) or charge enable (sel 1) to reach lvl
  task automatic wait_lvl(input int sel, input logic lvl, input int lim, output int k);
    k = 0;
    while ((sel ? charge_en : alert_oe) !== lvl) begin
      @(negedge ref_clk);
      k++;
      if (k > lim) begin
        errors++;
        $display("[FAIL] wait level expected %b seen timeout", lvl);
        close_out();
      end
    end
  endtask
  // Raise one cause, time the debounce, drop it, time the hold
  task automatic alert_case(input int src, input logic [15:0] w2, input int deb, input int hold);
    int m;
    wr(8'h3D, w2);
    trip = 3'b001 << src;
    wait_lvl(0, 1'b1, deb * 100 + 400, m);
    chk_rng("debounce", deb * 100 - 100, deb * 100 + 200, m);
    trip = 3'b000;
    wait_lvl(0, 1'b0, hold * 100 + 400, m);
    chk_rng("hold", hold * 100 - 150, hold * 100 + 200, m);
  endtask
  // ****************************************
  // Clock and sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    errors = 0;
    check_count = 0;
    srst = 1'b1;
    adapter = 1'b0;
    batt_lp = 1'b1;
    trip = 3'b000;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("amps at reset", 16'h000C, {11'h000, amps});
    chk("threshold source", 16'h0001, {15'h0000, thr_cfg});
    // Reset values, then write and read back every word
    for (int i = 0; i < 5; i++) begin
      rd_chk(cmds[i], 16'h0000);
      wr(cmds[i], vals[i]);
      rd_chk(cmds[i], vals[i]);
    end
    // Unknown code taken but dropped; foreign address refused
    wr(8'h20, 16'h1234);
    rd_chk(8'h20, 16'h0000);
    i_host.write_word(7'h0A, 8'h39, 16'hFFFF, acks);
    chk("foreign acks", 16'h000F, {12'h000, acks});
    rd_chk(8'h39, vals[0]);
    // Word zero decode over all offset codes, watchdog enabled without adapter
    for (int i = 0; i < 8; i++) begin
      wr(8'h39, (i << 10) | ((i & 3) << 5) | ((i & 3) << 3) | ((i & 1) << 2));
      repeat (4) @(negedge ref_clk);
      chk("hs short", {6'h00, hs_tab[i & 3]}, {6'h00, hs_mv});
      chk("offset", 16'(i[2] ? i + 8 : i), {12'h000, ofs});
      chk("amps", 16'(12 - 2 * (i & 3)), {11'h000, amps});
      chk("vin loop", 16'(!(i & 1)), {15'h0000, vin_en});
    end
    chk("charge without adapter", 16'h0001, {15'h0000, charge_en});
    // Watchdog expiry with adapter, then ceiling write resumes
    adapter = 1'b1;
    wait_lvl(1, 1'b0, 3000, n);
    chk_rng("watchdog", 1900, 2300, n);
    rd_chk(`CCR_CMD_STATUS, 16'h0001);
    wr(8'h39, 16'h0080);
    wr(`CCR_CMD_CHG_VOLT, 16'h1000);
    repeat (4) @(negedge ref_clk);
    rd_chk(`CCR_CMD_STATUS, 16'h0004);
    // Alert timing for each cause and code pair
    alert_case(0, 16'h0040, 10, 100);
    alert_case(1, 16'h0200, 100, 10);
    alert_case(2, 16'h0600, 10, 10);
    // Battery only: discharge alert needs the power monitor enable
    adapter = 1'b0;
    wr(8'h3C, 16'h0000);
    trip = 3'b010;
    repeat (1500) @(negedge ref_clk);
    chk("alert without monitor", 16'h0000, {15'h0000, alert_oe});
    trip = 3'b000;
    wr(8'h3C, 16'h0008);
    alert_case(1, 16'h0000, 10, 10);
    close_out();
  end
endmodule
